// *** hw/urx_pkg.sv ***
// shared constants and types of the serial receiver
package urx_pkg;

  // ---------------------------------------------------------------
  // oversampling and bit timing
  // ---------------------------------------------------------------
  localparam int OVS_RATE = 16;
  localparam logic [3:0] SAMPLE_FIRST = 4'h7;
  localparam logic [3:0] SAMPLE_LAST = 4'h9;
  localparam logic [3:0] BIT_DECIDE = 4'(OVS_RATE - 1);
  localparam int DIV_W = 16;
  localparam logic [DIV_W-1:0] TICK_RST = 16'h0000;

  // ---------------------------------------------------------------
  // word format
  // ---------------------------------------------------------------
  localparam logic [3:0] BITS_SHORT = 4'h8;
  localparam logic [3:0] BITS_LONG = 4'h9;
  localparam int WORD_W = 9;

  // ---------------------------------------------------------------
  // buffer entry layout: word, framing error, parity error
  // ---------------------------------------------------------------
  localparam int FE_POS = 9;
  localparam int PE_POS = 10;
  localparam int ENTRY_W = 11;
  localparam int FIFO_DEPTH = 2;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic IDLE_RST = 1'b1;
  localparam logic FLAG_RST = 1'b0;

  typedef enum logic [2:0] {
    URX_IDLE,
    URX_START,
    URX_DATA,
    URX_STOP,
    URX_WAIT_HIGH
  } urx_state_t;

endpackage

// *** hw/urx_fifo_if.sv ***
// link between the receiver core and its word buffer
`timescale 1ns/100ps
`default_nettype none
interface urx_fifo_if #(parameter int W = 11) ();
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;
  logic flush;

  modport producer (
    output push_valid, push_data, pop_ready, flush,
    input push_ready, pop_valid, pop_data
  );
  modport store (
    input push_valid, push_data, pop_ready, flush,
    output push_ready, pop_valid, pop_data
  );
endinterface
`default_nettype wire

// *** hw/urx_fifo.sv ***
// small word buffer in flip-flops with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module urx_fifo import urx_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int W = ENTRY_W
) (
  input wire logic core_clk,
  input wire logic rst_n,
  urx_fifo_if.store fb
);

  localparam int AW = (DEPTH > 2) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [CW-1:0] count, next_count;
  logic do_push, do_pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  // ---------------------------------------------------------------
  // handshake and pointer update
  // ---------------------------------------------------------------
  assign fb.push_ready = (count != CW'(DEPTH));
  assign fb.pop_valid = (count != '0);
  assign fb.pop_data = mem[rd_ptr];
  assign do_push = fb.push_valid && fb.push_ready && !fb.flush;
  assign do_pop = fb.pop_ready && fb.pop_valid && !fb.flush;

  always_comb begin
    next_wr_ptr = do_push ? bump(wr_ptr) : wr_ptr;
    next_rd_ptr = do_pop ? bump(rd_ptr) : rd_ptr;
    next_count = count;
    if (fb.flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count = '0;
    end else if (do_push && !do_pop) begin
      next_count = CW'(count + 1'b1);
    end else if (do_pop && !do_push) begin
      next_count = CW'(count - 1'b1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // storage carries no reset; count alone says what is valid
  always_ff @(posedge core_clk) begin
    if (do_push) begin
      mem[wr_ptr] <= fb.push_data;
    end
  end

  property p_fifo_depth;
    @(posedge core_clk) disable iff (!rst_n) count <= CW'(DEPTH);
  endproperty
  a_fifo_depth: assert property (p_fifo_depth) else $error("buffer count above depth");

  property p_full_keeps;
    @(posedge core_clk) disable iff (!rst_n)
      (!fb.push_ready && !fb.pop_ready && !fb.flush) |=> (count == CW'(DEPTH));
  endproperty
  a_full_keeps: assert property (p_full_keeps) else $error("full buffer lost an entry");

endmodule // urx_fifo
`default_nettype wire

// *** hw/urx_top.sv ***
// receive half of an asynchronous serial port with error flags
//
// Contract
// - words are 8 or 9 bits; in 9-bit mode the top bit shows as ninth bit
// - recovery runs at sixteen ticks per bit; shifter advances once per bit
// - each bit level is a majority vote of three samples
// - after the stop bit the word moves to the buffer if it has room
// - serial data enters least significant bit first
// - the buffer holds two words while a third keeps arriving
// - third word into full buffer sets overrun, keeps buffer, drops word
// - with receiver enabled the line is watched for a start bit
// - data-available is set while the buffer holds at least one word
// - status read then data read clears overrun and noise; data-available clears when the buffer empties
// - with interrupts enabled, each transfer and each overrun requests one
// - a break is a framing error: zero word, data-available, idle set
// - after a break no new start is seen until the line is high
// - idle reads zero from start detect to stop, one otherwise
// - noise still transfers the word and sets noise with data-available
// - a low stop bit sets the framing error flag
// - framing and parity errors travel with the word; reset clears them
// - with parity enabled, a mismatch to odd or even sets parity error
// - the shift register is never visible to software
// - port disable empties buffer, clears flags and sets idle
// - only one stop bit is checked per frame
`timescale 1ns/100ps
`default_nettype none
module urx_top import urx_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic rx_in,
  input wire logic port_enable,
  input wire logic receiver_enable,
  input wire logic word_length_select,
  input wire logic parity_enable,
  input wire logic parity_type_select,
  input wire logic rx_interrupt_enable,
  input wire logic [DIV_W-1:0] baud_divisor,
  input wire logic status_read,
  input wire logic data_read,
  output logic [7:0] rx_data,
  output logic ninth_rx_bit,
  output logic rx_data_available_flag,
  output logic overrun_flag,
  output logic noise_flag,
  output logic framing_error_flag,
  output logic parity_error_flag,
  output logic receiver_idle_flag,
  output logic rx_irq
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic maj3(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic split3(input logic [2:0] s);
    return (s != 3'h0) && (s != 3'h7);
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  urx_state_t state, next_state;
  logic [DIV_W-1:0] tick_cnt, next_tick_cnt;
  logic [3:0] os_cnt, next_os_cnt;
  logic [2:0] samp, next_samp;
  logic [3:0] bit_idx, next_bit_idx;
  logic [WORD_W-1:0] rx_shift_register, next_rx_shift_register;
  logic noisy, next_noisy;
  logic rx_prev;
  logic armed, next_armed;
  logic next_overrun, next_noise, next_idle, next_irq;
  logic active, tick, decide, bit_level, bit_noise, noisy_all;
  logic [3:0] nbits;
  logic [WORD_W-1:0] word;
  logic stop_bad, par_bad, accept, clear_seq;

  urx_fifo_if #(.W(ENTRY_W)) fb ();

  urx_fifo #(.DEPTH(FIFO_DEPTH), .W(ENTRY_W)) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .fb(fb)
  );

  // ---------------------------------------------------------------
  // bit timing and sampling
  // ---------------------------------------------------------------
  assign active = port_enable && receiver_enable;
  assign tick = (tick_cnt == baud_divisor);
  assign decide = tick && (os_cnt == BIT_DECIDE);
  assign bit_level = maj3(samp);
  assign bit_noise = split3(samp);
  assign noisy_all = noisy || bit_noise;
  assign nbits = word_length_select ? BITS_LONG : BITS_SHORT;

  // 8-bit words sit in the upper shifter bits after eight shifts
  assign word = word_length_select ? rx_shift_register
                                   : {1'b0, rx_shift_register[WORD_W-1:1]};
  // a low first stop bit is a framing error
  assign stop_bad = !bit_level;
  // parity bit is the top word bit
  assign par_bad = parity_enable && ((^word) != parity_type_select);

  // ---------------------------------------------------------------
  // buffer side
  // ---------------------------------------------------------------
  // hand over on the stop decision
  assign fb.push_valid = active && (state == URX_STOP) && decide;
  // error bits stored with the word
  assign fb.push_data = {par_bad, stop_bad, word};
  assign fb.pop_ready = data_read;
  assign fb.flush = !port_enable;
  assign accept = fb.push_valid && fb.push_ready;
  // status access followed by data read
  assign clear_seq = armed && data_read;

  assign rx_data = fb.pop_data[7:0];
  // ninth bit from the buffer head
  assign ninth_rx_bit = fb.pop_data[8];
  assign rx_data_available_flag = fb.pop_valid;
  // head flags readable before the word is popped
  assign framing_error_flag = fb.pop_valid && fb.pop_data[FE_POS];
  assign parity_error_flag = fb.pop_valid && fb.pop_data[PE_POS];

  // ---------------------------------------------------------------
  // frame sequencer next values
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_tick_cnt = tick ? TICK_RST : DIV_W'(tick_cnt + 1'b1);
    next_os_cnt = tick ? 4'(os_cnt + 1'b1) : os_cnt;
    next_samp = samp;
    next_bit_idx = bit_idx;
    next_rx_shift_register = rx_shift_register;
    next_noisy = noisy;
    next_idle = receiver_idle_flag;
    if (tick && (os_cnt >= SAMPLE_FIRST) && (os_cnt <= SAMPLE_LAST)) begin
      next_samp = {samp[1:0], rx_in};
    end
    case (state)
      URX_IDLE: begin
        next_os_cnt = 4'h0;
        if (active && rx_prev && !rx_in) begin
          next_state = URX_START;
          next_tick_cnt = TICK_RST;
          next_noisy = 1'b0;
          next_bit_idx = 4'h0;
          next_idle = 1'b0;
        end
      end
      URX_START: begin
        if (decide) begin
          next_noisy = noisy_all;
          // a high start level was a glitch
          if (bit_level) begin
            next_state = URX_IDLE;
            next_idle = 1'b1;
          end else begin
            next_state = URX_DATA;
          end
        end
      end
      URX_DATA: begin
        if (decide) begin
          next_rx_shift_register = {bit_level, rx_shift_register[WORD_W-1:1]};
          next_noisy = noisy_all;
          next_bit_idx = 4'(bit_idx + 1'b1);
          // frame length follows the word length select
          if (bit_idx == 4'(nbits - 1'b1)) begin
            next_state = URX_STOP;
          end
        end
      end
      URX_STOP: begin
        if (decide) begin
          // a break ends here as a zero word
          // idle rises once the stop bit is read
          next_idle = 1'b1;
          // a low stop holds off the next start
          next_state = stop_bad ? URX_WAIT_HIGH : URX_IDLE;
        end
      end
      URX_WAIT_HIGH: begin
        if (rx_in) begin
          next_state = URX_IDLE;
        end
      end
      default: begin
        next_state = URX_IDLE;
      end
    endcase
    // a dropped enable aborts any frame in progress
    if (!active) begin
      next_state = URX_IDLE;
      next_idle = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= URX_IDLE;
      tick_cnt <= TICK_RST;
      os_cnt <= 4'h0;
      samp <= 3'h7;
      bit_idx <= 4'h0;
      rx_shift_register <= '0;
      noisy <= FLAG_RST;
      receiver_idle_flag <= IDLE_RST;
      rx_prev <= 1'b1;
    end else begin
      state <= next_state;
      tick_cnt <= next_tick_cnt;
      os_cnt <= next_os_cnt;
      samp <= next_samp;
      bit_idx <= next_bit_idx;
      rx_shift_register <= next_rx_shift_register;
      noisy <= next_noisy;
      receiver_idle_flag <= next_idle;
      rx_prev <= rx_in;
    end
  end

  // ---------------------------------------------------------------
  // status flags and interrupt request
  // ---------------------------------------------------------------
  // a set in the same cycle as the clearing read wins, so no event is lost
  always_comb begin
    next_armed = armed;
    next_overrun = overrun_flag;
    next_noise = noise_flag;
    if (status_read) begin
      next_armed = 1'b1;
    end else if (data_read) begin
      next_armed = 1'b0;
    end
    if (clear_seq) begin
      next_overrun = 1'b0;
      next_noise = 1'b0;
    end
    // full buffer drops the new word
    if (fb.push_valid && !fb.push_ready) begin
      next_overrun = 1'b1;
    end
    if (accept && noisy_all) begin
      next_noise = 1'b1;
    end
    next_irq = rx_interrupt_enable && fb.push_valid;
    if (!port_enable) begin
      next_armed = 1'b0;
      next_overrun = 1'b0;
      next_noise = 1'b0;
      next_irq = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      armed <= FLAG_RST;
      overrun_flag <= FLAG_RST;
      noise_flag <= FLAG_RST;
      rx_irq <= FLAG_RST;
    end else begin
      armed <= next_armed;
      overrun_flag <= next_overrun;
      noise_flag <= next_noise;
      rx_irq <= next_irq;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_push_avail;
    accept |=> rx_data_available_flag;
  endproperty
  a_push_avail: assert property (p_push_avail) else $error("word stored but not available");

  property p_overrun;
    (fb.push_valid && !fb.push_ready) |=> overrun_flag && rx_data_available_flag;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_irq;
    (fb.push_valid && rx_interrupt_enable) |=> rx_irq ##1 !rx_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("missing one-cycle request");

  property p_irq_masked;
    !rx_interrupt_enable |=> !rx_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("request while masked");

  property p_idle_in_frame;
    (state == URX_DATA) |-> !receiver_idle_flag;
  endproperty
  a_idle_in_frame: assert property (p_idle_in_frame) else $error("idle high mid-frame");

  property p_disable;
    !port_enable |=> receiver_idle_flag && !rx_data_available_flag && !overrun_flag;
  endproperty
  a_disable: assert property (p_disable) else $error("disable left state behind");

  property p_clear;
    (clear_seq && !fb.push_valid && port_enable) |=> !overrun_flag && !noise_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("clear sequence failed");

  property p_break_hold;
    (state == URX_WAIT_HIGH && !rx_in && active) |=> (state == URX_WAIT_HIGH);
  endproperty
  a_break_hold: assert property (p_break_hold) else $error("left break wait on low line");

  property p_false_start;
    (state == URX_START && decide && bit_level && active) |=> (state == URX_IDLE);
  endproperty
  a_false_start: assert property (p_false_start) else $error("glitch taken as start");

  property p_frame_error;
    (fb.push_valid && ($countones(samp) < 2)) |-> fb.push_data[FE_POS];
  endproperty
  a_frame_error: assert property (p_frame_error) else $error("low stop not flagged");

endmodule // urx_top
`default_nettype wire

// *** bench/urx_line_model.sv ***
// behavioural remote transmitter that drives the serial line
`timescale 1ns/100ps
`default_nettype none
module urx_line_model #(
  parameter int BIT_CLKS = 16
) (
  input wire logic core_clk,
  output logic rx_line
);
  logic b;
  // bit length in clocks; the bench retunes it together with the divisor
  int bit_clks = BIT_CLKS;

  // line rests high between frames
  initial rx_line = 1'b1;

  // ---------------------------------------------------------------
  // frame sender: start, n word bits, one stop bit
  // ---------------------------------------------------------------
  // lsb goes first
  task automatic send(input logic [8:0] w, input int n, input logic stop_v, input int noisy);
    for (int i = 0; i <= n + 1; i++) begin
      b = (i == 0) ? 1'b0 : (i <= n) ? w[i-1] : stop_v;
      for (int c = 0; c < bit_clks; c++) begin
        @(negedge core_clk);
        // one flipped clock mid-bit disturbs a single vote sample only
        rx_line <= (i == noisy && c == bit_clks / 2) ? ~b : b;
      end
    end
    // a low stop is released so the receiver can rearm
    @(negedge core_clk);
    rx_line <= 1'b1;
  endtask

  // long low level, then back to the idle level
  task automatic brk(input int nbits);
    @(negedge core_clk);
    rx_line <= 1'b0;
    repeat (nbits * bit_clks) @(negedge core_clk);
    rx_line <= 1'b1;
  endtask

  // short low pulse that is no real start bit
  task automatic glitch(input int clks);
    @(negedge core_clk);
    rx_line <= 1'b0;
    repeat (clks) @(negedge core_clk);
    rx_line <= 1'b1;
  endtask
endmodule // urx_line_model
`default_nettype wire

// *** bench/test_urx_top.sv ***
// self-checking bench for the serial receiver
`timescale 1ns/100ps
`default_nettype none
module test_urx_top;
  import urx_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic rx_in;
  logic port_enable = 1'b1;
  logic receiver_enable = 1'b1;
  logic word_length_select = 1'b0;
  logic parity_enable = 1'b0;
  logic parity_type_select = 1'b0;
  logic rx_interrupt_enable = 1'b1;
  logic [DIV_W-1:0] baud_divisor = 16'h0000;
  logic status_read = 1'b0;
  logic data_read = 1'b0;
  logic [7:0] rx_data;
  logic ninth_rx_bit, rx_data_available_flag, overrun_flag, noise_flag;
  logic framing_error_flag, parity_error_flag, receiver_idle_flag, rx_irq;
  int err_total = 0;
  int total_checks = 0;
  int seed = 47;
  int cyc = 0;
  int irq_seen = 0;
  int irq_exp = 0;
  int n;
  logic rd_en = 1'b1;
  logic [8:0] w;
  logic [12:0] e;
  logic [12:0] q[$];

  urx_top dut (.core_clk(core_clk), .rst_n(rst_n), .rx_in(rx_in),
    .port_enable(port_enable), .receiver_enable(receiver_enable),
    .word_length_select(word_length_select), .parity_enable(parity_enable),
    .parity_type_select(parity_type_select), .rx_interrupt_enable(rx_interrupt_enable),
    .baud_divisor(baud_divisor), .status_read(status_read), .data_read(data_read),
    .rx_data(rx_data), .ninth_rx_bit(ninth_rx_bit),
    .rx_data_available_flag(rx_data_available_flag), .overrun_flag(overrun_flag),
    .noise_flag(noise_flag), .framing_error_flag(framing_error_flag),
    .parity_error_flag(parity_error_flag), .receiver_idle_flag(receiver_idle_flag),
    .rx_irq(rx_irq));
  urx_line_model #(.BIT_CLKS(16)) line (.core_clk(core_clk), .rx_line(rx_in));

  always #5 core_clk = ~core_clk;

  task automatic chk(input string nm, input logic [8:0] ex, input logic [8:0] got);
    total_checks++;
    if (got !== ex) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // single status bits compared without padding
  task automatic chk_flag(input string nm, input logic ex, input logic got);
    total_checks++;
    if (got !== ex) begin
      err_total++;
      $display("MISMATCH %s expected %b seen %b", nm, ex, got);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // hang guard, far above the few thousand cycles the run needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  always @(posedge core_clk) if (rx_irq === 1'b1) irq_seen++;

  // ---------------------------------------------------------------
  // reader: flags first, then the word, as software must
  // ---------------------------------------------------------------
  // flags before data
  always @(negedge core_clk) begin
    if (rst_n && rd_en && rx_data_available_flag === 1'b1) begin
      e = (q.size() > 0) ? q.pop_front() : 13'h1fff;
      chk("word", e[8:0], {ninth_rx_bit, rx_data});
      chk_flag("framing", e[9], framing_error_flag);
      chk_flag("parity", e[10], parity_error_flag);
      chk_flag("noise", e[11], noise_flag);
      chk_flag("overrun", e[12], overrun_flag);
      chk_flag("idle", 1'b1, receiver_idle_flag);
      status_read = 1'b1;
      @(negedge core_clk);
      status_read = 1'b0;
      data_read = 1'b1;
      @(negedge core_clk);
      data_read = 1'b0;
      @(negedge core_clk);
    end
  end

  // note the expectation, then let the far side send the frame
  task automatic fr(input logic [8:0] wd, input logic st, input int nb,
                    input logic fe, input logic pe, input logic nf);
    q.push_back({1'b0, nf, pe, fe, wd});
    if (rx_interrupt_enable) irq_exp++;
    line.send(wd, word_length_select ? 9 : 8, st, nb);
    repeat (4) @(negedge core_clk);
  endtask

  initial begin
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    // plain words in both lengths, interrupts on and off
    for (int i = 0; i < 8; i++) begin
      word_length_select = i[0];
      rx_interrupt_enable = i[1];
      w = 9'($random(seed));
      if (!i[0]) w[8] = 1'b0;
      fr(w, 1'b1, -1, 1'b0, 1'b0, 1'b0);
    end
    // both parity senses in both lengths, good and bad
    parity_enable = 1'b1;
    for (int i = 0; i < 8; i++) begin
      word_length_select = i[0];
      parity_type_select = i[1];
      n = i[0] ? 9 : 8;
      w = 9'($random(seed)) & 9'((1 << (n - 1)) - 1);
      w[n-1] = ^w ^ i[1] ^ i[2];
      fr(w, 1'b1, -1, 1'b0, i[2], 1'b0);
    end
    parity_enable = 1'b0;
    word_length_select = 1'b0;
    // slower bit clock: one oversample tick every second clock
    baud_divisor = 16'h0001;
    line.bit_clks = 32;
    fr(9'h05a, 1'b1, -1, 1'b0, 1'b0, 1'b0);
    baud_divisor = 16'h0000;
    line.bit_clks = 16;
    // idle drops while a frame is in flight
    fork
      fr(9'h0a5, 1'b1, -1, 1'b0, 1'b0, 1'b0);
      begin
        repeat (60) @(negedge core_clk);
        chk_flag("idle busy", 1'b0, receiver_idle_flag);
      end
    join
    fr(9'h03c, 1'b0, -1, 1'b1, 1'b0, 1'b0);
    fr(9'h0c3, 1'b1, 3, 1'b0, 1'b0, 1'b1);
    // break: zero word with framing error, nothing more while low
    q.push_back(13'h0200);
    irq_exp++;
    line.brk(13);
    repeat (4) @(negedge core_clk);
    // receiver off: the line is ignored
    receiver_enable = 1'b0;
    line.send(9'h055, 8, 1'b1, -1);
    repeat (4) @(negedge core_clk);
    chk_flag("ignored", 1'b0, rx_data_available_flag);
    receiver_enable = 1'b1;
    // a low pulse shorter than half a bit is dropped at the start vote
    line.glitch(4);
    repeat (40) @(negedge core_clk);
    chk_flag("glitch word", 1'b0, rx_data_available_flag);
    chk_flag("glitch idle", 1'b1, receiver_idle_flag);
    // reader stalls on purpose: third word overruns a full buffer
    rd_en = 1'b0;
    for (int i = 0; i < 3; i++) begin
      w = 9'($random(seed)) & 9'h0ff;
      if (i < 2) q.push_back({i == 0, 3'b000, w});
      line.send(w, 8, 1'b1, -1);
    end
    irq_exp += 3;
    repeat (4) @(negedge core_clk);
    chk_flag("two held", 1'b1, rx_data_available_flag);
    chk_flag("overrun set", 1'b1, overrun_flag);
    rd_en = 1'b1;
    repeat (20) @(negedge core_clk);
    chk_flag("drained", 1'b0, rx_data_available_flag);
    // port disable flushes a held bad word
    rd_en = 1'b0;
    line.send(9'h081, 8, 1'b0, -1);
    irq_exp++;
    repeat (4) @(negedge core_clk);
    port_enable = 1'b0;
    @(negedge core_clk);
    port_enable = 1'b1;
    @(negedge core_clk);
    chk_flag("flushed", 1'b0, rx_data_available_flag);
    chk_flag("fe cleared", 1'b0, framing_error_flag);
    chk_flag("idle set", 1'b1, receiver_idle_flag);
    rd_en = 1'b1;
    repeat (10) @(negedge core_clk);
    chk("irq count", 9'(irq_exp), 9'(irq_seen));
    chk("notes left", 9'h000, 9'(q.size()));
    give_verdict();
  end
endmodule // test_urx_top
`default_nettype wire
